// [occ_pkg.sv]
// Overview of operation
// - the current clock source is a read-only three-bit field with seven source codes, code 100 being reserved.
// - software writes the requested clock source in the same encoding, reset from configuration straps.
// - software sets switch_request to ask for a switch and the device clears it when the switch is done.
// - with clock_config_lock set and clock_monitor_config high, clock and pll settings cannot be changed.
// - pin_mapping_lock is a writable bit whose set state activates the pin mapping lock.
// - the pll lock status reads one when the pll is locked, else zero.
// - clock_fail_flag is set when the fail safe clock monitor detects a failure.
// - software writing clock_fail_flag to one acts exactly as a real failure and raises the failure trap.
// - writes to the oscillator control register are taken only right after an unlock sequence.
// - with recover_on_interrupt set an interrupt clears ratio_enable, giving a 1:1 peripheral ratio.
// - peripheral_ratio sets the ratio while ratio_enable is one, and writes to it are ignored then.
// - a set of ratio_enable is ignored while peripheral_ratio is 000.
// - pll_input_divider divides the pll input by its code plus two, from 2 to 33.
// - rc_trim is a signed six-bit code that shifts the fast rc frequency.
// - the pll multiplier is pll_feedback_divider plus two, output is input times it over both dividers.
package occ_pkg;
    // ==========================================
    // register offsets
    localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
    localparam logic [3:0] OFS_CLK_DIV  = 4'h1;
    localparam logic [3:0] OFS_PLL_FBD  = 4'h2;
    localparam logic [3:0] OFS_RC_TRIM  = 4'h3;
    localparam logic [3:0] OFS_UNLOCK   = 4'h4;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h6;
    localparam logic [3:0] OFS_FACTORS  = 4'h7;
    // ==========================================
    // unlock sequence keys
    localparam logic [15:0] KEY_FIRST  = 16'h0057;
    localparam logic [15:0] KEY_SECOND = 16'h00aa;
    // ==========================================
    // oscillator control fields
    localparam int CUR_LSB  = 12;
    localparam int REQ_LSB  = 8;
    localparam int CFGL_BIT = 7;
    localparam int PINL_BIT = 6;
    localparam int LOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int SWR_BIT  = 0;
    // ==========================================
    // clock divisor fields
    localparam int ROI_BIT  = 15;
    localparam int RAT_LSB  = 12;
    localparam int REN_BIT  = 11;
    localparam int RCP_LSB  = 8;
    localparam int POST_LSB = 6;
    localparam int PRE_LSB  = 0;
    // ==========================================
    // reset values, reserved codes and constants
    localparam logic [2:0] RATIO_RST = 3'h3;
    localparam logic [1:0] POST_RST  = 2'h1;
    localparam logic [8:0] FBD_RST   = 9'h030;
    localparam logic [2:0] RATIO_OFF = 3'h0;
    localparam logic [1:0] POST_RSVD = 2'h2;
    localparam logic [2:0] SRC_RSVD  = 3'h4;
    localparam logic [9:0] PLUS_TWO  = 10'h002;
    // ==========================================
    // interrupt status bits
    localparam int IRQ_FAIL = 0;
    localparam int IRQ_SWDN = 1;
    localparam int IRQ_W    = 2;
    // ==========================================
    // clock sources
    typedef enum logic [2:0] {
        SRC_FAST_RC        = 3'h0,
        SRC_FAST_RC_WITH_PLL = 3'h1,
        SRC_PRIMARY        = 3'h2,
        SRC_PRIMARY_PLL    = 3'h3,
        SRC_LOW_POWER_RC   = 3'h5,
        SRC_FAST_RC_DIV16  = 3'h6,
        SRC_FAST_RC_DIVN   = 3'h7
    } occ_src_t;
endpackage : occ_pkg

// [occ_top.sv]
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module occ_top (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [15:0] rdata,
    input  wire logic [2:0]  cfg_source,
    input  wire logic        clock_monitor_config,
    input  wire logic        pll_locked_in,
    input  wire logic        switch_done_in,
    input  wire logic        clock_fail_in,
    input  wire logic        cpu_irq_in,
    output logic      [2:0]  current_clock_source,
    output logic      [2:0]  switch_target,
    output logic             switch_go,
    output logic             pin_mapping_lock,
    output logic             clock_fail_trap,
    output logic      [2:0]  doze_ratio_out,
    output logic             ratio_enable,
    output logic      [2:0]  rc_postscaler,
    output logic      [6:0]  rc_post_factor,
    output logic      [5:0]  pll_n1,
    output logic      [3:0]  pll_n2,
    output logic      [9:0]  pll_m,
    output logic      [5:0]  rc_trim,
    output logic             irq
);
    // ==========================================
    // pin synchronisers
    typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_OPEN} occ_ul_t;
    logic [4:0] sync1_reg, sync2_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end else begin
            sync1_reg <= {cpu_irq_in, clock_fail_in, switch_done_in, pll_locked_in, clock_monitor_config};
            sync2_reg <= sync1_reg;
        end
    end
    wire logic mon_cfg  = sync2_reg[0];
    wire logic pll_lk   = sync2_reg[1];
    wire logic sw_done  = sync2_reg[2];
    wire logic fail_det = sync2_reg[3];
    wire logic cpu_irq  = sync2_reg[4];
    // ==========================================
    // decode
    logic wr_osc, wr_div, wr_fbd, wr_trim, wr_ul, wr_st, wr_mk;
    always_comb begin
        wr_osc = 1'b0; wr_div = 1'b0; wr_fbd = 1'b0; wr_trim = 1'b0;
        wr_ul = 1'b0; wr_st = 1'b0; wr_mk = 1'b0;
        if (!wr_stb) begin
            wr_osc = 1'b0;
        end else if (addr == occ_pkg::OFS_OSC_CTRL) begin
            wr_osc = 1'b1;
        end else if (addr == occ_pkg::OFS_CLK_DIV) begin
            wr_div = 1'b1;
        end else if (addr == occ_pkg::OFS_PLL_FBD) begin
            wr_fbd = 1'b1;
        end else if (addr == occ_pkg::OFS_RC_TRIM) begin
            wr_trim = 1'b1;
        end else if (addr == occ_pkg::OFS_UNLOCK) begin
            wr_ul = 1'b1;
        end else if (addr == occ_pkg::OFS_IRQ_STAT) begin
            wr_st = 1'b1;
        end else if (addr == occ_pkg::OFS_IRQ_MASK) begin
            wr_mk = 1'b1;
        end
    end
    // ==========================================
    // unlock sequence
    occ_ul_t ul_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ul_reg <= UL_IDLE;
        end else begin
            case (ul_reg)
                UL_IDLE: if (wr_ul && wdata == occ_pkg::KEY_FIRST) ul_reg <= UL_KEY1;
                UL_KEY1: begin
                    if (wr_ul && wdata == occ_pkg::KEY_SECOND) ul_reg <= UL_OPEN;
                    else if (wr_stb || rd_stb) ul_reg <= UL_IDLE;
                end
                UL_OPEN: if (wr_stb || rd_stb) ul_reg <= UL_IDLE;
                default: ul_reg <= UL_IDLE;
            endcase
        end
    end
    logic pin_cfg_lock_reg;
    wire logic osc_ok  = wr_osc && ul_reg == UL_OPEN;
    wire logic cfg_lk  = pin_cfg_lock_reg && mon_cfg;
    // ==========================================
    // strap capture after reset release
    logic strap_done_reg;
    logic [2:0] req_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            strap_done_reg <= 1'b0;
            req_reg        <= 3'h0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            req_reg        <= cfg_source;
        end else if (osc_ok && !cfg_lk) begin
            req_reg <= wdata[occ_pkg::REQ_LSB +: 3];
        end
    end
    // ==========================================
    // oscillator control state
    logic swr_reg, cf_reg, lock_reg;
    wire logic sw_set = osc_ok && !cfg_lk && wdata[occ_pkg::SWR_BIT] && !swr_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            swr_reg              <= 1'b0;
            current_clock_source <= 3'h0;
            switch_target        <= 3'h0;
            switch_go            <= 1'b0;
        end else begin
            switch_go <= sw_set;
            if (sw_set) begin
                swr_reg       <= 1'b1;
                switch_target <= wdata[occ_pkg::REQ_LSB +: 3];
            end else if (swr_reg && sw_done) begin
                swr_reg              <= 1'b0;
                current_clock_source <= switch_target;
            end
            if (!strap_done_reg) begin
                current_clock_source <= cfg_source;
                switch_target        <= cfg_source;
            end
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_cfg_lock_reg <= 1'b0;
            pin_mapping_lock <= 1'b0;
            lock_reg         <= 1'b0;
        end else begin
            lock_reg <= pll_lk;
            if (osc_ok) begin
                pin_mapping_lock <= wdata[occ_pkg::PINL_BIT];
                if (!cfg_lk) pin_cfg_lock_reg <= wdata[occ_pkg::CFGL_BIT];
            end
        end
    end
    wire logic sw_fail = osc_ok && wdata[occ_pkg::FAIL_BIT];
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cf_reg          <= 1'b0;
            clock_fail_trap <= 1'b0;
        end else begin
            clock_fail_trap <= (fail_det || sw_fail) && !cf_reg;
            if (fail_det || sw_fail) cf_reg <= 1'b1;
            else if (osc_ok) cf_reg <= 1'b0;
        end
    end
    // ==========================================
    // clock divisor
    logic roi_reg;
    logic [2:0] ratio_reg;
    logic [1:0] post_reg;
    logic [4:0] pre_reg;
    logic [8:0] fbd_reg;
    wire logic [2:0] w_ratio = ratio_enable ? ratio_reg : wdata[occ_pkg::RAT_LSB +: 3];
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            roi_reg       <= 1'b0;
            ratio_reg     <= occ_pkg::RATIO_RST;
            ratio_enable  <= 1'b0;
            rc_postscaler <= 3'h0;
            post_reg      <= occ_pkg::POST_RST;
            pre_reg       <= 5'h00;
        end else begin
            if (wr_div) begin
                roi_reg   <= wdata[occ_pkg::ROI_BIT];
                ratio_reg <= w_ratio;
                ratio_enable <= wdata[occ_pkg::REN_BIT] && w_ratio != occ_pkg::RATIO_OFF;
                rc_postscaler <= wdata[occ_pkg::RCP_LSB +: 3];
                if (!cfg_lk) begin
                    if (wdata[occ_pkg::POST_LSB +: 2] != occ_pkg::POST_RSVD) post_reg <= wdata[occ_pkg::POST_LSB +: 2];
                    pre_reg <= wdata[occ_pkg::PRE_LSB +: 5];
                end
            end
            if (roi_reg && cpu_irq) ratio_enable <= 1'b0;
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fbd_reg <= occ_pkg::FBD_RST;
            rc_trim <= 6'h00;
        end else begin
            if (wr_fbd && !cfg_lk) fbd_reg <= wdata[8:0];
            if (wr_trim) rc_trim <= wdata[5:0];
        end
    end
    // ==========================================
    // derived factors
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            doze_ratio_out <= 3'h0;
            pll_n1         <= 6'h02;
            pll_n2         <= 4'h4;
            pll_m          <= 10'h032;
            rc_post_factor <= 7'h01;
        end else begin
            doze_ratio_out <= ratio_enable ? ratio_reg : occ_pkg::RATIO_OFF;
            pll_n1         <= {1'b0, pre_reg} + 6'h02;
            pll_n2         <= {1'b0, post_reg, 1'b0} + 4'h2;
            pll_m          <= {1'b0, fbd_reg} + occ_pkg::PLUS_TWO;
            rc_post_factor <= 7'h01 << rc_postscaler;
        end
    end
    // ==========================================
    // interrupts
    logic [occ_pkg::IRQ_W-1:0] st_reg, mk_reg;
    wire logic [occ_pkg::IRQ_W-1:0] ev = {swr_reg && sw_done, fail_det || sw_fail};
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            mk_reg <= '0;
            irq    <= 1'b0;
        end else begin
            st_reg <= ev | (st_reg & ~(wr_st ? wdata[occ_pkg::IRQ_W-1:0] : '0));
            if (wr_mk) mk_reg <= wdata[occ_pkg::IRQ_W-1:0];
            irq <= |(st_reg & mk_reg);
        end
    end
    // ==========================================
    // read back
    logic [15:0] rd_next;
    always_comb begin
        rd_next = 16'h0000;
        if (addr == occ_pkg::OFS_OSC_CTRL) begin
            rd_next[occ_pkg::CUR_LSB +: 3] = current_clock_source;
            rd_next[occ_pkg::REQ_LSB +: 3] = req_reg;
            rd_next[occ_pkg::CFGL_BIT]     = pin_cfg_lock_reg;
            rd_next[occ_pkg::PINL_BIT]     = pin_mapping_lock;
            rd_next[occ_pkg::LOCK_BIT]     = lock_reg;
            rd_next[occ_pkg::FAIL_BIT]     = cf_reg;
            rd_next[occ_pkg::SWR_BIT]      = swr_reg;
        end else if (addr == occ_pkg::OFS_CLK_DIV) begin
            rd_next = {roi_reg, ratio_reg, ratio_enable, rc_postscaler, post_reg, 1'b0, pre_reg};
        end else if (addr == occ_pkg::OFS_PLL_FBD) begin
            rd_next = {7'h00, fbd_reg};
        end else if (addr == occ_pkg::OFS_RC_TRIM) begin
            rd_next = {10'h000, rc_trim};
        end else if (addr == occ_pkg::OFS_UNLOCK) begin
            rd_next = {14'h0000, ul_reg};
        end else if (addr == occ_pkg::OFS_IRQ_STAT) begin
            rd_next = {14'h0000, st_reg};
        end else if (addr == occ_pkg::OFS_IRQ_MASK) begin
            rd_next = {14'h0000, mk_reg};
        end else if (addr == occ_pkg::OFS_FACTORS) begin
            rd_next = {pll_m[5:0], pll_n2, pll_n1};
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) rdata <= 16'h0000;
        else rdata <= rd_stb ? rd_next : 16'h0000;
    end
    // ==========================================
    // checks
    chk_switch_clear: assert property (@(posedge clock) disable iff (!resetn)
        swr_reg && sw_done && !sw_set |=> !swr_reg) else $error("switch request not cleared");
    chk_unlock_gate: assert property (@(posedge clock) disable iff (!resetn)
        wr_osc && ul_reg != UL_OPEN && strap_done_reg |=> $stable(req_reg)) else $error("locked write taken");
    chk_cfg_lock: assert property (@(posedge clock) disable iff (!resetn)
        cfg_lk && strap_done_reg |=> $stable(fbd_reg) && $stable(pre_reg)) else $error("locked pll changed");
    chk_roi_clear: assert property (@(posedge clock) disable iff (!resetn)
        roi_reg && cpu_irq |=> !ratio_enable) else $error("ratio not recovered");
    chk_ratio_hold: assert property (@(posedge clock) disable iff (!resetn)
        ratio_enable |=> $stable(ratio_reg)) else $error("ratio changed while enabled");
    chk_zero_ratio: assert property (@(posedge clock) disable iff (!resetn)
        ratio_enable |-> ratio_reg != occ_pkg::RATIO_OFF) else $error("enable with zero ratio");
    chk_fail_set: assert property (@(posedge clock) disable iff (!resetn)
        fail_det |=> cf_reg ##1 st_reg[occ_pkg::IRQ_FAIL]) else $error("fail flag missed");
    chk_sw_trap: assert property (@(posedge clock) disable iff (!resetn)
        sw_fail && !cf_reg |=> clock_fail_trap && cf_reg) else $error("trap not raised");
    chk_lock_stat: assert property (@(posedge clock) disable iff (!resetn)
        pll_lk |=> lock_reg) else $error("lock status wrong");
    chk_pll_mult: assert property (@(posedge clock) disable iff (!resetn)
        ##1 pll_m == {1'b0, $past(fbd_reg)} + occ_pkg::PLUS_TWO) else $error("multiplier wrong");
    cov_switch: cover property (@(posedge clock) sw_set ##[1:20] !swr_reg);
    cov_trap:   cover property (@(posedge clock) clock_fail_trap);
    cov_roi:    cover property (@(posedge clock) ratio_enable ##1 !ratio_enable);
endmodule : occ_top
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ==========================================
    // signals
    typedef struct packed {
        logic [3:0]  a;
        logic [15:0] d;
        logic [15:0] q;
        logic [32:0] o;
    } occ_row_t;
    logic        clock;
    logic        resetn;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [15:0] rdata;
    logic [2:0]  cfg_source;
    logic        clock_monitor_config;
    logic        pll_locked_in;
    logic        switch_done_in;
    logic        clock_fail_in;
    logic        cpu_irq_in;
    logic [2:0]  current_clock_source;
    logic [2:0]  switch_target;
    logic        switch_go;
    logic        pin_mapping_lock;
    logic        clock_fail_trap;
    logic [2:0]  doze_ratio_out;
    logic        ratio_enable;
    logic [2:0]  rc_postscaler;
    logic [6:0]  rc_post_factor;
    logic [5:0]  pll_n1;
    logic [3:0]  pll_n2;
    logic [9:0]  pll_m;
    logic [5:0]  rc_trim;
    logic        irq;
    logic [15:0] v;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cyc_cnt   = 0;
    int          trap_cnt  = 0;
    int          go_cnt    = 0;
    localparam occ_row_t ROWS [8] = '{
        '{4'h1, 16'h06ff, 16'h06df, {6'h21, 4'h8, 10'h032, 7'h40, 6'h00}},
        '{4'h1, 16'h0280, 16'h02c0, {6'h02, 4'h8, 10'h032, 7'h04, 6'h00}},
        '{4'h1, 16'h0040, 16'h0040, {6'h02, 4'h4, 10'h032, 7'h01, 6'h00}},
        '{4'h2, 16'hffff, 16'h01ff, {6'h02, 4'h4, 10'h201, 7'h01, 6'h00}},
        '{4'h2, 16'h0000, 16'h0000, {6'h02, 4'h4, 10'h002, 7'h01, 6'h00}},
        '{4'h3, 16'hffff, 16'h003f, {6'h02, 4'h4, 10'h002, 7'h01, 6'h3f}},
        '{4'h3, 16'h0020, 16'h0020, {6'h02, 4'h4, 10'h002, 7'h01, 6'h20}},
        '{4'h8, 16'hffff, 16'h0000, {6'h02, 4'h4, 10'h002, 7'h01, 6'h20}}
    };
    // ==========================================
    // design
    occ_top dut_u (
        .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .cfg_source(cfg_source), .clock_monitor_config(clock_monitor_config),
        .pll_locked_in(pll_locked_in), .switch_done_in(switch_done_in), .clock_fail_in(clock_fail_in),
        .cpu_irq_in(cpu_irq_in), .current_clock_source(current_clock_source), .switch_target(switch_target),
        .switch_go(switch_go), .pin_mapping_lock(pin_mapping_lock), .clock_fail_trap(clock_fail_trap),
        .doze_ratio_out(doze_ratio_out), .ratio_enable(ratio_enable), .rc_postscaler(rc_postscaler),
        .rc_post_factor(rc_post_factor), .pll_n1(pll_n1), .pll_n2(pll_n2), .pll_m(pll_m),
        .rc_trim(rc_trim), .irq(irq)
    );
    // ==========================================
    // clock, pulse counters, timeout
    always #25 clock = ~clock;
    always @(negedge clock) begin
        if (clock_fail_trap === 1'b1) trap_cnt <= trap_cnt + 1;
        if (switch_go === 1'b1) go_cnt <= go_cnt + 1;
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            error_cnt = error_cnt + 1;
            print_verdict();
        end
    end
    // ==========================================
    // tasks
    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        addr   <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 d = rdata;
        @(posedge clock);
    endtask : rd
    task automatic cyc(input int n);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        repeat (n) @(posedge clock);
    endtask : cyc
    task automatic osc_wr(input logic [15:0] d);
        wr(occ_pkg::OFS_UNLOCK, occ_pkg::KEY_FIRST);
        wr(occ_pkg::OFS_UNLOCK, occ_pkg::KEY_SECOND);
        wr(occ_pkg::OFS_OSC_CTRL, d);
        cyc(3);
    endtask : osc_wr
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] exp);
        rd(a, v);
        chk(nm, v, exp);
    endtask : rd_chk
    task automatic pulse_irq();
        cpu_irq_in <= 1'b1;
        cyc(3);
        cpu_irq_in <= 1'b0;
        cyc(4);
    endtask : pulse_irq
    task automatic print_verdict();
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // ==========================================
    // main sequence
    initial begin
        clock = 0; resetn = 0; addr = '0; wdata = '0; wr_stb = 0; rd_stb = 0; cfg_source = 3'h7;
        clock_monitor_config = 1; pll_locked_in = 0; switch_done_in = 0; clock_fail_in = 0; cpu_irq_in = 0;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        cyc(2);
        rd_chk("osc_rst", occ_pkg::OFS_OSC_CTRL, 16'h7700);
        rd_chk("div_rst", occ_pkg::OFS_CLK_DIV, 16'h3040);
        rd_chk("fbd_rst", occ_pkg::OFS_PLL_FBD, 16'h0030);
        chk("fac_rst", {pll_n1, pll_n2, pll_m, rc_post_factor}, {6'h02, 4'h4, 10'h032, 7'h01});
        chk("src_rst", {current_clock_source, rc_postscaler}, {3'h7, 3'h0});
        $display("test reset done");
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            rd_chk("row_read", ROWS[i].a, ROWS[i].q);
            cyc(2);
            chk("row_out", {pll_n1, pll_n2, pll_m, rc_post_factor, rc_trim}, ROWS[i].o);
        end
        $display("test rows done");
        wr(occ_pkg::OFS_OSC_CTRL, 16'h0040);
        wr(occ_pkg::OFS_UNLOCK, occ_pkg::KEY_FIRST);
        rd(occ_pkg::OFS_CLK_DIV, v);
        wr(occ_pkg::OFS_UNLOCK, occ_pkg::KEY_SECOND);
        wr(occ_pkg::OFS_OSC_CTRL, 16'h0040);
        cyc(3);
        chk("pin_nolock", pin_mapping_lock, 1'b0);
        osc_wr(16'h0041);
        chk("pin_lock", pin_mapping_lock, 1'b1);
        chk("target", switch_target, occ_pkg::SRC_FAST_RC);
        rd_chk("osc_req", occ_pkg::OFS_OSC_CTRL, 16'h7041);
        switch_done_in <= 1'b1;
        cyc(5);
        switch_done_in <= 1'b0;
        rd_chk("osc_done", occ_pkg::OFS_OSC_CTRL, 16'h0040);
        chk("go_cnt", go_cnt, 1);
        chk("cur_src", current_clock_source, occ_pkg::SRC_FAST_RC);
        chk("irq_masked", irq, 1'b0);
        wr(occ_pkg::OFS_IRQ_MASK, 16'h0002);
        cyc(3);
        chk("irq_sw", irq, 1'b1);
        wr(occ_pkg::OFS_IRQ_STAT, 16'h0002);
        cyc(3);
        chk("irq_clr", irq, 1'b0);
        $display("test switch done");
        pll_locked_in <= 1'b1;
        cyc(3);
        rd_chk("pll_lock", occ_pkg::OFS_OSC_CTRL, 16'h0060);
        wr(occ_pkg::OFS_IRQ_MASK, 16'h0001);
        clock_fail_in <= 1'b1;
        cyc(4);
        clock_fail_in <= 1'b0;
        cyc(2);
        rd_chk("fail_hw", occ_pkg::OFS_OSC_CTRL, 16'h0068);
        chk("trap_hw", trap_cnt, 1);
        chk("irq_fail", irq, 1'b1);
        wr(occ_pkg::OFS_IRQ_STAT, 16'h0001);
        osc_wr(16'h0040);
        rd_chk("fail_clr", occ_pkg::OFS_OSC_CTRL, 16'h0060);
        chk("irq_off", irq, 1'b0);
        osc_wr(16'h0048);
        chk("trap_sw", trap_cnt, 2);
        rd_chk("fail_sw", occ_pkg::OFS_OSC_CTRL, 16'h0068);
        chk("irq_swfail", irq, 1'b1);
        wr(occ_pkg::OFS_IRQ_STAT, 16'h0001);
        osc_wr(16'h0040);
        $display("test fail done");
        wr(occ_pkg::OFS_CLK_DIV, 16'h0840);
        cyc(3);
        chk("ren_zero", ratio_enable, 1'b0);
        wr(occ_pkg::OFS_CLK_DIV, 16'h5840);
        wr(occ_pkg::OFS_CLK_DIV, 16'h2840);
        cyc(3);
        chk("doze_on", {ratio_enable, doze_ratio_out}, 4'hd);
        rd_chk("ratio_hold", occ_pkg::OFS_CLK_DIV, 16'h5840);
        pulse_irq();
        chk("no_roi", ratio_enable, 1'b1);
        wr(occ_pkg::OFS_CLK_DIV, 16'hd840);
        pulse_irq();
        chk("roi", {ratio_enable, doze_ratio_out}, 4'h0);
        rd_chk("roi_rd", occ_pkg::OFS_CLK_DIV, 16'hd040);
        $display("test doze done");
        osc_wr(16'h00c0);
        wr(occ_pkg::OFS_PLL_FBD, 16'h0055);
        rd_chk("fbd_lock", occ_pkg::OFS_PLL_FBD, 16'h0000);
        osc_wr(16'h0241);
        rd_chk("osc_lock", occ_pkg::OFS_OSC_CTRL, 16'h00e0);
        clock_monitor_config <= 1'b0;
        cyc(3);
        wr(occ_pkg::OFS_PLL_FBD, 16'h0055);
        rd_chk("fbd_free", occ_pkg::OFS_PLL_FBD, 16'h0055);
        $display("test lock done");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
